/* File: hdl/pcr_pkg.sv */
// constants and types shared by the coding-sublayer and media-interface register bank
package pcr_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;          // 100 MHz system clock
    localparam int TMO_SHORT_US = 722;          // short descrambler timeout, microseconds
    localparam int TMO_LONG_MS = 2;             // long descrambler timeout, milliseconds
    localparam int unsigned TMO_SHORT_CYC_DEF = TMO_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned TMO_LONG_CYC_DEF = TMO_LONG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TMO_CNT_W = 18;              // wide enough for the long timeout

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int ADR_W = 8;                   // wishbone byte address width
    localparam logic [5:0] PCS_CFG_IDX = 6'h16; // pcs_config_status
    localparam logic [5:0] RMII_CFG_IDX = 6'h17; // rmii_bypass_config

    // ------------------------------------------------------------------
    // pcs_config_status field positions
    // ------------------------------------------------------------------
    localparam int PCS_FREE_CLK_BIT = 11;       // receive clock control, storage only
    localparam int PCS_TQ_BIT = 10;             // true_quiet_enable
    localparam int PCS_SDF_BIT = 9;             // signal_detect_force
    localparam int PCS_SDOPT_BIT = 8;           // signal_detect_policy
    localparam int PCS_DTIME_BIT = 7;           // descrambler_timeout_select
    localparam int PCS_F100_BIT = 5;            // force good 100 Mb/s link
    localparam int PCS_NRZI_BIT = 2;            // nrzi bypass

    // ------------------------------------------------------------------
    // rmii_bypass_config field positions
    // ------------------------------------------------------------------
    localparam int RMII_MODE_BIT = 5;           // reduced mii select
    localparam int RMII_OLD_BIT = 4;            // reduced_mii_old_revision

    // ------------------------------------------------------------------
    // reset values and bus constants
    // ------------------------------------------------------------------
    localparam logic SDOPT_RST = 1'b1;          // link held on signal level alone
    localparam logic CFG_OFF = 1'b0;            // reset value of all other fields
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [3:0] ZERO4 = 4'h0;
    localparam logic [TMO_CNT_W-1:0] TMO_ZERO = 18'h00000;

    // ------------------------------------------------------------------
    // state of the register bank
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ack;                        // wishbone acknowledge
        logic [31:0] rdata;               // registered read data
        logic free_clk;
        logic true_quiet_enable;
        logic signal_detect_force;
        logic signal_detect_policy;
        logic descrambler_timeout_select;
        logic force_good;
        logic nrzi_bypass;
        logic rmii_mode;
        logic reduced_mii_old_revision;
        logic strap_done;                 // strap captured after reset release
        logic link;                       // link state machine
        logic link_o;                     // reported 100 Mb/s link
        logic sig_det_o;                  // signal detect towards the pma
        logic [TMO_CNT_W-1:0] tmo_cnt;    // descrambler timeout counter
        logic tmo_pulse;                  // resync request
    } pcr_state_t;

    // ------------------------------------------------------------------
    // state of the crs_dv generator
    // ------------------------------------------------------------------
    typedef struct packed {
        logic tog;                        // toggle phase after carrier drop
        logic crs_o;                      // mii carrier sense pin
        logic rx_dv_o;                    // mii rx_dv or rmii crs_dv pin
        logic [3:0] rxd_o;                // receive data pins
    } pcr_crs_state_t;

endpackage

/* File: hdl/pcr_crs_dv.sv */
// receive-side pin stage: mii pass-through or rmii crs_dv generation
`timescale 1ns/1ps
module pcr_crs_dv
    import pcr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // configuration
    input wire logic rmii_mode_i,
    input wire logic old_rev_i,
    // receive path from the coding sublayer
    input wire logic crs_i,
    input wire logic rx_dv_i,
    input wire logic [3:0] rxd_i,
    // pins towards the mac
    output logic crs_o,
    output logic rx_dv_o,
    output logic [3:0] rxd_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam pcr_crs_state_t CRS_RST = '{tog: 1'b0, crs_o: 1'b0, rx_dv_o: 1'b0, rxd_o: ZERO4};
    pcr_crs_state_t st_reg; // registered state
    pcr_crs_state_t st_next; // next state

    // next-state logic
    always_comb
    begin
        st_next = st_reg;
        st_next.rxd_o = rxd_i;
        if (!rmii_mode_i)
        begin
            // plain mii: pins follow the path untouched, rmii logic idle
            st_next.crs_o = crs_i;
            st_next.rx_dv_o = rx_dv_i;
            st_next.tog = 1'b0;
        end
        else if (old_rev_i)
        begin
            // older revision: held high until the last data leaves
            st_next.crs_o = 1'b0;
            st_next.rx_dv_o = crs_i | rx_dv_i;
            st_next.tog = 1'b0;
        end
        else
        begin
            st_next.crs_o = 1'b0;
            if (crs_i)
            begin
                // carrier present: steady high
                st_next.rx_dv_o = 1'b1;
                st_next.tog = 1'b0;
            end
            else if (rx_dv_i)
            begin
                // carrier gone, data still draining: toggle, low first
                st_next.rx_dv_o = st_reg.tog;
                st_next.tog = ~st_reg.tog;
            end
            else
            begin
                // idle line
                st_next.rx_dv_o = 1'b0;
                st_next.tog = 1'b0;
            end
        end
    end

    // state register, frozen while the enable is low
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_reg <= CRS_RST;
        else if (ce_i)
            st_reg <= st_next;
    end

    assign crs_o = st_reg.crs_o;
    assign rx_dv_o = st_reg.rx_dv_o;
    assign rxd_o = st_reg.rxd_o;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    mii_bypass_a: assert property (
        (ce_i && !rmii_mode_i) |=> (rx_dv_o == $past(rx_dv_i)) && (crs_o == $past(crs_i)))
        else $error("mii path altered while rmii is off");

    old_rev_hold_a: assert property (
        (ce_i && rmii_mode_i && old_rev_i && (crs_i || rx_dv_i)) |=> rx_dv_o)
        else $error("crs_dv dropped before data end in old revision");

    toggle_end_a: assert property (
        (ce_i && rmii_mode_i && !old_rev_i && !crs_i && rx_dv_i && !st_reg.tog)
        ##1 (ce_i && rmii_mode_i && !old_rev_i && !crs_i && rx_dv_i)
        |=> !$past(rx_dv_o) && rx_dv_o)
        else $error("crs_dv did not toggle after carrier drop");

    toggle_c: cover property (rmii_mode_i && !old_rev_i && !crs_i && rx_dv_i && st_reg.tog);

endmodule

/* File: hdl/pcr_regs.sv */
// coding-sublayer and media-interface configuration registers with link policy logic
//
// Functional notes
// - unused upper bits ignore writes, read zero
// - bit 10 selects true quiet transmit
// - bit 9 forces signal detect present
// - policy set: link holds on signal level
// - policy clear: link drops on lock loss
// - bit 7 selects 722 us or 2 ms
// - bit 5 forces good 100 Mb/s link
// - bit 2 bypasses nrzi coding
// - rmii mode bit resets from strap
// - revision 1.2: crs_dv toggles at end
// - revision 1.0: crs_dv held until done
// - mii mode bypasses rmii logic entirely
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module pcr_regs
    import pcr_pkg::*;
#(
    parameter int unsigned TMO_SHORT_CYC = TMO_SHORT_CYC_DEF, // short timeout in cycles
    parameter int unsigned TMO_LONG_CYC = TMO_LONG_CYC_DEF    // long timeout in cycles
)
(
    // clock, reset, enable
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    // wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // strap and pma / descrambler status
    input wire logic RMII_STRAP_I,
    input wire logic SIG_LEVEL_I,
    input wire logic DESCR_LOCK_I,
    input wire logic DESCR_IDLE_I,
    // controls towards the 100 Mb/s path
    output logic TRUE_QUIET_O,
    output logic NRZI_BYPASS_O,
    output logic SIGNAL_DETECT_O,
    output logic LINK_100_OK_O,
    output logic DESCR_TIMEOUT_O,
    output logic RMII_MODE_O,
    // receive path from the coding sublayer
    input wire logic RX_CRS_I,
    input wire logic RX_DV_I,
    input wire logic [3:0] RXD_I,
    // receive pins towards the mac
    output logic CRS_O,
    output logic RX_DV_O,
    output logic [3:0] RXD_O
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam pcr_state_t REG_RST = '{
        ack: 1'b0, rdata: ZERO32, free_clk: CFG_OFF, true_quiet_enable: CFG_OFF,
        signal_detect_force: CFG_OFF, signal_detect_policy: SDOPT_RST,
        descrambler_timeout_select: CFG_OFF, force_good: CFG_OFF, nrzi_bypass: CFG_OFF,
        rmii_mode: CFG_OFF, reduced_mii_old_revision: CFG_OFF, strap_done: 1'b0,
        link: 1'b0, link_o: 1'b0, sig_det_o: 1'b0, tmo_cnt: TMO_ZERO, tmo_pulse: 1'b0};

    pcr_state_t st_reg; // registered state
    pcr_state_t st_next; // next state
    logic take; // bus request accepted this cycle
    logic hit_pcs; // address selects pcs_config_status
    logic hit_rmii; // address selects rmii_bypass_config
    logic sig_eff; // signal level after the force bit
    logic [TMO_CNT_W-1:0] tmo_last; // last count before the timeout fires
    logic [15:0] pcs_word; // read image of pcs_config_status
    logic [15:0] rmii_word; // read image of rmii_bypass_config

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // low two address bits are ignored: every register is one aligned word
    assign take = WB_CYC_I && WB_STB_I && !st_reg.ack;
    assign hit_pcs = (WB_ADR_I[ADR_W-1:2] == PCS_CFG_IDX);
    assign hit_rmii = (WB_ADR_I[ADR_W-1:2] == RMII_CFG_IDX);

    // timeout length follows the select bit
    assign tmo_last = st_reg.descrambler_timeout_select
        ? TMO_CNT_W'(TMO_LONG_CYC - 1)
        : TMO_CNT_W'(TMO_SHORT_CYC - 1);

    // forced detect is seen by the link logic as well as the pma output
    assign sig_eff = SIG_LEVEL_I || st_reg.signal_detect_force;

    // read images: unlisted and reserved positions stay zero
    always_comb
    begin
        pcs_word = ZERO16;
        pcs_word[PCS_FREE_CLK_BIT] = st_reg.free_clk;
        pcs_word[PCS_TQ_BIT] = st_reg.true_quiet_enable;
        pcs_word[PCS_SDF_BIT] = st_reg.signal_detect_force;
        pcs_word[PCS_SDOPT_BIT] = st_reg.signal_detect_policy;
        pcs_word[PCS_DTIME_BIT] = st_reg.descrambler_timeout_select;
        pcs_word[PCS_F100_BIT] = st_reg.force_good;
        pcs_word[PCS_NRZI_BIT] = st_reg.nrzi_bypass;
        rmii_word = ZERO16;
        rmii_word[RMII_MODE_BIT] = st_reg.rmii_mode;
        rmii_word[RMII_OLD_BIT] = st_reg.reduced_mii_old_revision;
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        // ack lasts one cycle; the master must drop stb before the next request
        st_next.ack = take;
        // strap is caught on the first enabled edge after reset release
        if (!st_reg.strap_done)
        begin
            st_next.rmii_mode = RMII_STRAP_I;
            st_next.strap_done = 1'b1;
        end
        // reads: unmapped addresses answer zero
        if (take && !WB_WE_I)
        begin
            if (hit_pcs)
                st_next.rdata = {ZERO16, pcs_word};
            else if (hit_rmii)
                st_next.rdata = {ZERO16, rmii_word};
            else
                st_next.rdata = ZERO32;
        end
        // writes: only defined fields are stored, others are dropped
        if (take && WB_WE_I && hit_pcs)
        begin
            if (WB_SEL_I[1])
            begin
                st_next.free_clk = WB_DAT_I[PCS_FREE_CLK_BIT];
                st_next.true_quiet_enable = WB_DAT_I[PCS_TQ_BIT];
                st_next.signal_detect_force = WB_DAT_I[PCS_SDF_BIT];
                st_next.signal_detect_policy = WB_DAT_I[PCS_SDOPT_BIT];
            end
            if (WB_SEL_I[0])
            begin
                st_next.descrambler_timeout_select = WB_DAT_I[PCS_DTIME_BIT];
                st_next.force_good = WB_DAT_I[PCS_F100_BIT];
                st_next.nrzi_bypass = WB_DAT_I[PCS_NRZI_BIT];
            end
        end
        // a bus write after the strap cycle overrides the strapped mode
        if (take && WB_WE_I && hit_rmii && WB_SEL_I[0])
        begin
            st_next.rmii_mode = WB_DAT_I[RMII_MODE_BIT];
            st_next.reduced_mii_old_revision = WB_DAT_I[RMII_OLD_BIT];
        end
        // link state machine
        if (!st_reg.link)
        begin
            // rises only with both signal detect (level or force bit) and descrambler lock
            st_next.link = sig_eff && DESCR_LOCK_I;
        end
        else if (st_reg.signal_detect_policy)
        begin
            // lock loss is tolerated as long as the signal stays
            st_next.link = sig_eff;
        end
        else
        begin
            st_next.link = sig_eff && DESCR_LOCK_I;
        end
        // reported link: the force bit overrides everything
        st_next.link_o = st_next.link || st_reg.force_good;
        st_next.sig_det_o = sig_eff;
        // descrambler watchdog: idle symbols or lock loss restart it
        st_next.tmo_pulse = 1'b0;
        if (!DESCR_LOCK_I || DESCR_IDLE_I)
            st_next.tmo_cnt = TMO_ZERO;
        else if (st_reg.tmo_cnt >= tmo_last)
        begin
            // a shortened select while running fires at once, never wraps late
            st_next.tmo_cnt = TMO_ZERO;
            st_next.tmo_pulse = 1'b1;
        end
        else
            st_next.tmo_cnt = st_reg.tmo_cnt + 1'b1;
    end

    // state register, frozen while the enable is low
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            st_reg <= REG_RST;
        else if (CE_I)
            st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign WB_ACK_O = st_reg.ack;
    assign WB_DAT_O = st_reg.rdata;
    assign TRUE_QUIET_O = st_reg.true_quiet_enable;
    assign NRZI_BYPASS_O = st_reg.nrzi_bypass;
    assign SIGNAL_DETECT_O = st_reg.sig_det_o;
    assign LINK_100_OK_O = st_reg.link_o;
    assign DESCR_TIMEOUT_O = st_reg.tmo_pulse;
    assign RMII_MODE_O = st_reg.rmii_mode;

    // receive pin stage, steered by the media-interface register
    pcr_crs_dv u_crs_dv (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .ce_i(CE_I),
        .rmii_mode_i(st_reg.rmii_mode),
        .old_rev_i(st_reg.reduced_mii_old_revision),
        .crs_i(RX_CRS_I),
        .rx_dv_i(RX_DV_I),
        .rxd_i(RXD_I),
        .crs_o(CRS_O),
        .rx_dv_o(RX_DV_O),
        .rxd_o(RXD_O)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    reserved_zero_a: assert property (
        (WB_ACK_O && !WB_WE_I && hit_pcs) |-> (WB_DAT_O[31:12] == 20'h00000))
        else $error("reserved bits read nonzero");

    true_quiet_wr_a: assert property (
        (CE_I && take && WB_WE_I && hit_pcs && WB_SEL_I[1])
        |=> TRUE_QUIET_O == $past(WB_DAT_I[PCS_TQ_BIT]))
        else $error("true quiet output not updated by write");

    sd_force_a: assert property (
        (CE_I && st_reg.signal_detect_force) |=> SIGNAL_DETECT_O)
        else $error("forced signal detect not reported");

    link_rise_a: assert property (
        (CE_I && !st_reg.link && SIG_LEVEL_I && DESCR_LOCK_I) |=> st_reg.link ##1 1'b1)
        else $error("link did not rise on level and lock");

    link_hold_a: assert property (
        (CE_I && st_reg.link && st_reg.signal_detect_policy && SIG_LEVEL_I && !DESCR_LOCK_I)
        |=> st_reg.link)
        else $error("link dropped on lock loss under hold policy");

    link_drop_a: assert property (
        (CE_I && st_reg.link && !st_reg.signal_detect_policy && !DESCR_LOCK_I)
        |=> !st_reg.link)
        else $error("link kept after lock loss under strict policy");

    timeout_len_a: assert property (
        $rose(DESCR_TIMEOUT_O) |-> $past(st_reg.tmo_cnt) >= $past(tmo_last))
        else $error("descrambler timeout fired early");

    force_good_a: assert property (
        (CE_I && st_reg.force_good) |=> LINK_100_OK_O)
        else $error("forced good link not reported");

    nrzi_wr_a: assert property (
        (CE_I && take && WB_WE_I && hit_pcs && WB_SEL_I[0])
        |=> NRZI_BYPASS_O == $past(WB_DAT_I[PCS_NRZI_BIT]))
        else $error("nrzi bypass not updated by write");

    strap_cap_a: assert property (
        // a bus write in the strap cycle legally wins over the strap
        ($rose(st_reg.strap_done) && !$past(take && WB_WE_I && hit_rmii && WB_SEL_I[0]))
        |-> RMII_MODE_O == $past(RMII_STRAP_I))
        else $error("rmii mode not taken from strap");

    free_clk_rd_a: assert property (
        (WB_ACK_O && !WB_WE_I && hit_pcs) |-> WB_DAT_O[PCS_FREE_CLK_BIT] == st_reg.free_clk)
        else $error("receive clock bit reads back wrong");

    write_c: cover property (take && WB_WE_I && hit_rmii ##1 WB_ACK_O);
    link_up_c: cover property (!st_reg.link ##1 st_reg.link);
    timeout_c: cover property (DESCR_TIMEOUT_O);
    hold_c: cover property (st_reg.link && st_reg.signal_detect_policy && !DESCR_LOCK_I);

endmodule

/* File: tb/pcr_rx_src.sv */
// receive frame source standing in for the coding sublayer
`timescale 1ns/1ps
module pcr_rx_src
(
    // clock and frame trigger
    input wire logic clk_i,
    input wire logic start_i,
    // receive path into the block
    output logic crs_o,
    output logic dv_o,
    output logic [3:0] rxd_o
);
    logic [3:0] step_reg = 4'h0; // frame position, zero when idle

    // carrier for four cycles, then a three-cycle tail with carrier already gone,
    // which is the awkward end-of-frame case for the crs_dv generator
    always @(posedge clk_i)
    begin
        if (start_i || step_reg != 4'h0)
            step_reg <= (step_reg == 4'h8) ? 4'h0 : step_reg + 4'h1;
    end
    assign crs_o = (step_reg >= 4'h1) && (step_reg <= 4'h4);
    assign dv_o = (step_reg >= 4'h1) && (step_reg <= 4'h7);
    // nibbles change every cycle so a stuck data pin shows
    assign rxd_o = ~step_reg;
endmodule

/* File: tb/pcs_rmii_config_regs_test.sv */
// self-checking bench for the coding-sublayer and media-interface registers
`timescale 1ns/1ps
module pcs_rmii_config_regs_test;
    import pcr_pkg::*;
    localparam int SHORT = 20; // shortened timeouts keep the run brief
    localparam int LONG = 50;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, dat_o, rd;
    logic sig = 1'b0, lock = 1'b0, idle = 1'b0, start = 1'b0;
    logic ce = 1'b1, strap = 1'b1;
    logic crs, dv, tq, nrzi, sd, link, tmo, mode, crs_o, dv_o;
    logic [3:0] rxd, rxd_o;
    int err_count = 0, checks_done = 0, cycles = 0;

    always #5 clk = ~clk;
    pcr_regs #(.TMO_SHORT_CYC(SHORT), .TMO_LONG_CYC(LONG)) u_pcr_regs (.CLK_I(clk),
        .ARST_N_I(rst_n), .CE_I(ce), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .RMII_STRAP_I(strap), .SIG_LEVEL_I(sig), .DESCR_LOCK_I(lock), .DESCR_IDLE_I(idle),
        .TRUE_QUIET_O(tq), .NRZI_BYPASS_O(nrzi), .SIGNAL_DETECT_O(sd), .LINK_100_OK_O(link),
        .DESCR_TIMEOUT_O(tmo), .RMII_MODE_O(mode), .RX_CRS_I(crs), .RX_DV_I(dv),
        .RXD_I(rxd), .CRS_O(crs_o), .RX_DV_O(dv_o), .RXD_O(rxd_o));
    pcr_rx_src u_pcr_rx_src (.clk_i(clk), .start_i(start), .crs_o(crs), .dv_o(dv),
        .rxd_o(rxd));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_fields;
        rdchk(8'h58, 32'h0000_0100);
        rdchk(8'h5C, 32'h0000_0020);
        chk(mode, 1'b1);
        wb(1'b1, 8'h58, 32'hFFFF_EFA4);
        rdchk(8'h58, 32'h0000_0FA4);
        chk(tq, 1'b1);
        chk(nrzi, 1'b1);
        wb(1'b1, 8'h5C, 32'hFFFF_FFFF);
        rdchk(8'h5C, 32'h0000_0030);
        wb(1'b1, 8'h60, 32'hFFFF_FFFF);
        rdchk(8'h60, 32'h0000_0000);
        wb(1'b1, 8'h58, 32'h0);
        chk(tq, 1'b0);
        chk(nrzi, 1'b0);
    endtask
    // link rise and fall under each policy, then the two force bits
    task automatic t_link(input logic pol);
        wb(1'b1, 8'h58, {23'h0, pol, 8'h00});
        sig <= 1'b1;
        lock <= 1'b1;
        repeat (3) @(posedge clk);
        chk(link, 1'b1);
        lock <= 1'b0;
        repeat (3) @(posedge clk);
        chk(link, pol);
        sig <= 1'b0;
        repeat (3) @(posedge clk);
        chk(link, 1'b0);
        wb(1'b1, 8'h58, 32'h0000_0220);
        repeat (2) @(posedge clk);
        chk(sd, 1'b1);
        chk(link, 1'b1);
    endtask
    // restart the watchdog with an idle pulse and count cycles to the resync pulse
    task automatic t_tmo(input logic long_sel);
        int n;
        n = 0;
        wb(1'b1, 8'h58, {24'h0, long_sel, 7'h00});
        lock <= 1'b1;
        idle <= 1'b1;
        repeat (2) @(posedge clk);
        idle <= 1'b0;
        while (tmo !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        chk(n, long_sel ? LONG : SHORT);
        @(posedge clk);
    endtask
    // one frame through the pin stage; expectation rebuilt from last cycle's inputs
    task automatic t_rx(input logic [31:0] cfg);
        logic pc, pd, e;
        logic [3:0] pr;
        int t;
        t = 0;
        wb(1'b1, 8'h5C, cfg);
        start <= 1'b1;
        repeat (12)
        begin
            @(posedge clk);
            start <= 1'b0;
            pc = crs;
            pd = dv;
            pr = rxd;
            e = !cfg[5] ? pd : (cfg[4] ? (pc | pd) : (pc || (pd && t[0])));
            t = (!pc && pd) ? t + 1 : 0;
            #1;
            chk(dv_o, e);
            chk(crs_o, cfg[5] ? 1'b0 : pc);
            chk(rxd_o, pr);
        end
        @(posedge clk);
    endtask
    // a low enable freezes the link logic; releasing it lets the link rise
    task automatic t_ce;
        ce <= 1'b0;
        sig <= 1'b1;
        lock <= 1'b1;
        repeat (3) @(posedge clk);
        chk(link, 1'b0);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk(link, 1'b1);
    endtask
    // second reset with the strap low: the mode bit must follow the strap
    task automatic t_strap;
        strap <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(mode, 1'b0);
        rdchk(8'h5C, 32'h0000_0000);
        rdchk(8'h58, 32'h0000_0100);
    endtask

    // cut a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_fields();
        t_link(1'b1);
        t_link(1'b0);
        t_tmo(1'b0);
        t_tmo(1'b1);
        t_ce();
        t_rx(32'h0000_0020);
        t_rx(32'h0000_0030);
        t_rx(32'h0000_0000);
        t_strap();
        tally_and_finish();
    end
endmodule
